/* port_power_mode_pin_logic.sv */
/*
  Control-pin logic of a USB port power switch with charger emulation:
  mode decode, power-up polarity latch, switch control, alert and attach
  outputs, and register override of the enable and mode pins.
  Assumes pins are asynchronous to clk, that override bits and charge
  events come from same-clock register logic, and that reset is held
  only at power-up.
*/
module port_power_mode_pin_logic (
  input  wire logic clk,                    // 200 MHz clock
  input  wire logic reset,                  // Power-up reset, sync high
  input  wire logic polarity_choice_pin,    // Enable polarity pin
  input  wire logic port_power_enable,      // Enable pin
  input  wire logic mode_select_one,        // Mode pin one
  input  wire logic mode_select_two,        // Mode pin two
  input  wire logic emulation_enable,       // Emulation pin
  input  wire logic pin_override_enable,    // Register override select
  input  wire logic ovr_power_enable,       // Register enable value
  input  wire logic ovr_mode_one,           // Register mode one value
  input  wire logic ovr_mode_two,           // Register mode two value
  input  wire logic ovr_emulation,          // Register emulation value
  input  wire logic attach_detect,          // Attach sensed, same clock
  input  wire logic fault_event,            // Fault pulse, same clock
  input  wire logic ration_reached,         // Ration limit pulse
  input  wire logic ration_clear,           // Software clear of ration
  input  wire logic fault_clear,            // Software clear of fault
  output logic      port_switch_closed,     // Power switch drive
  output logic      data_switch_closed,     // High-speed data switch
  output logic      emulation_active,       // Emulation engine allowed
  output logic [2:0] op_state_out,          // Current operating state
  output logic      polarity_latched,       // Latched polarity level
  output logic      fault_notify_n,         // Alert, active low
  output logic      attach_flag_n,          // Attach, active low
  output logic      charge_quota_done       // Ration complete status
);

  // Two-stage synchronisers for the five pins
  // The polarity pin rides the same chain so its one sample is clean.
  // No reset here: two edges after release flush the chain before it is read.
  logic [4:0] pin_meta;       // First stage, read only by second stage
  logic [4:0] pin_sync;       // Second stage, usable
  logic [4:0] next_pin_meta;
  logic [4:0] next_pin_sync;

  // Synchroniser next values
  always_comb begin
    next_pin_meta = {polarity_choice_pin, port_power_enable,
                     mode_select_one, mode_select_two, emulation_enable};
    next_pin_sync = pin_meta;
  end

  // Synchroniser registers
  always_ff @(posedge clk) begin
    pin_meta <= next_pin_meta;
    pin_sync <= next_pin_sync;
  end

  // Polarity latch state: taken once after reset release
  // Three edges after release: two to refill the chain, one to sample.
  // A pin bounce after that point cannot move the switch decision.
  logic polarity;
  logic polarity_taken;
  logic next_polarity;
  logic next_polarity_taken;
  logic [1:0] settle;          // Waits for sync chain to fill
  logic [1:0] next_settle;

  // Polarity capture next values
  always_comb begin
    next_polarity       = polarity;
    next_polarity_taken = polarity_taken;
    next_settle         = settle;
    // Only active while the first sample is still pending
    if (!polarity_taken) begin
      if (settle == 2'h2) begin
        next_polarity       = pin_sync[4];
        next_polarity_taken = 1'b1;
      end else begin
        // Chain not yet full of post-reset values
        next_settle = settle + 2'h1;
      end
    end
  end

  // Polarity capture registers; later pin changes never reach them
  always_ff @(posedge clk) begin
    if (reset) begin
      polarity       <= port_mode_pkg::RST_POLARITY;
      polarity_taken <= 1'b0;
      settle         <= 2'h0;
    end else begin
      polarity       <= next_polarity;
      polarity_taken <= next_polarity_taken;
      settle         <= next_settle;
    end
  end

  // Effective pin values after override
  // Override bits are same-clock values and need no chain, so an
  // override takes effect two edges sooner than a pin change.
  logic       eff_enable;
  logic [2:0] eff_mode;

  // Override multiplexer; the pins themselves are left as they are
  always_comb begin
    if (pin_override_enable) begin
      eff_enable = ovr_power_enable;
      eff_mode   = {ovr_mode_one, ovr_mode_two, ovr_emulation};
    end else begin
      eff_enable = pin_sync[3];
      eff_mode   = pin_sync[2:0];
    end
  end

  // Mode decoding shared with other users of the table
  // Decoder output is combinational; the output stage registers it.
  port_mode_pkg::op_state_e op_state;

  mode_decoder u_mode_decoder (
    .mode_word (eff_mode),
    .op_state  (op_state)
  );

  // Sticky flags: ration done and fault, set wins over clear
  // Clear is applied first and set last, so an event landing in the
  // same cycle as its clear is kept rather than lost.
  logic quota_done;
  logic fault_pend;
  logic next_quota_done;
  logic next_fault_pend;

  // Flag next values
  always_comb begin
    next_quota_done = quota_done;
    next_fault_pend = fault_pend;
    if (ration_clear) next_quota_done = 1'b0;
    if (fault_clear)  next_fault_pend = 1'b0;
    if (ration_reached) next_quota_done = 1'b1;
    if (fault_event)    next_fault_pend = 1'b1;
  end

  // Flag registers; cleared only by power-up reset or software
  always_ff @(posedge clk) begin
    if (reset) begin
      quota_done <= 1'b0;
      fault_pend <= 1'b0;
    end else begin
      quota_done <= next_quota_done;
      fault_pend <= next_fault_pend;
    end
  end

  // Output next values
  logic       next_port_switch;
  logic       next_data_switch;
  logic       next_emulation;
  logic       next_fault_n;
  logic       next_attach_n;

  // Output decisions
  // Next flag values are used so a ration event opens the switch on
  // the very edge that sets the flag, not one cycle later.
  always_comb begin
    next_port_switch = polarity_taken && (eff_enable == polarity);
    if (op_state == port_mode_pkg::OP_SAFE_OFF) next_port_switch = 1'b0;
    if (next_quota_done) next_port_switch = 1'b0;
    next_data_switch = next_port_switch &&
                       (op_state == port_mode_pkg::OP_PASS_THROUGH);
    next_emulation   = next_port_switch &&
                       (op_state != port_mode_pkg::OP_PASS_THROUGH);
    next_fault_n  = !(next_fault_pend || next_quota_done);
    next_attach_n = !attach_detect;
  end

  // Output registers
  // Every output is a flop; nothing combinational leaves the block.
  // Polarity goes out from its next value to line up with its latch.
  always_ff @(posedge clk) begin
    if (reset) begin
      // Switches open, flags idle
      port_switch_closed <= port_mode_pkg::RST_SWITCH;
      data_switch_closed <= 1'b0;
      emulation_active   <= 1'b0;
      op_state_out       <= port_mode_pkg::RST_MODE;
      polarity_latched   <= port_mode_pkg::RST_POLARITY;
      fault_notify_n     <= port_mode_pkg::RST_FLAG_N;
      attach_flag_n      <= port_mode_pkg::RST_FLAG_N;
      charge_quota_done  <= 1'b0;
    end else begin
      // Register the decisions
      port_switch_closed <= next_port_switch;
      data_switch_closed <= next_data_switch;
      emulation_active   <= next_emulation;
      op_state_out       <= op_state;
      polarity_latched   <= next_polarity;
      fault_notify_n     <= next_fault_n;
      attach_flag_n      <= next_attach_n;
      charge_quota_done  <= next_quota_done;
    end
  end

endmodule // port_power_mode_pin_logic

/* port_mode_pkg.sv */
/*
  Shared constants for the port power mode pin logic: operating state
  encodings, mode pin bit positions and reset values.
  Assumes a single 200 MHz clock domain and a synchronous active-high reset.
*/
package port_mode_pkg;

  // Operating states decoded from the three mode pins
  typedef enum logic [2:0] {
    OP_SAFE_OFF      = 3'h0,
    OP_EMU_CYCLE     = 3'h1,
    OP_PASS_THROUGH  = 3'h2,
    OP_BC_DCP        = 3'h3,
    OP_BC_SDP        = 3'h4,
    OP_BC_CDP        = 3'h5
  } op_state_e;

  // Bit positions inside the packed mode word {one, two, emulation}
  localparam int MODE_BIT_ONE = 2;
  localparam int MODE_BIT_TWO = 1;
  localparam int MODE_BIT_EMU = 0;
  localparam int MODE_WIDTH   = 3;

  // Reset values
  localparam logic       RST_POLARITY = 1'h1;
  localparam logic [2:0] RST_MODE     = 3'h0;
  localparam logic       RST_SWITCH   = 1'h0;
  localparam logic       RST_FLAG_N   = 1'h1;

endpackage : port_mode_pkg

/* mode_decoder.sv */
/*
  Combinational decoder from the packed mode word to an operating state.
  Assumes its input has already been synchronised and override-selected.
*/
module mode_decoder (
  input  wire logic [2:0]               mode_word,  // {one, two, emulation}
  output port_mode_pkg::op_state_e      op_state    // Decoded state
);

  // Decode table of mode combinations
  always_comb begin
    unique case (mode_word)
      3'h0: op_state = port_mode_pkg::OP_SAFE_OFF;
      3'h1: op_state = port_mode_pkg::OP_EMU_CYCLE;
      3'h5: op_state = port_mode_pkg::OP_EMU_CYCLE;
      3'h2: op_state = port_mode_pkg::OP_PASS_THROUGH;
      3'h6: op_state = port_mode_pkg::OP_PASS_THROUGH;
      3'h3: op_state = port_mode_pkg::OP_BC_DCP;
      3'h4: op_state = port_mode_pkg::OP_BC_SDP;
      3'h7: op_state = port_mode_pkg::OP_BC_CDP;
    endcase
  end

endmodule // mode_decoder

/* port_power_mode_chk.sv */
/* Checker for the port power mode pin logic.
   Assumes it is bound to the top module; one clock, sync reset. */
module port_power_mode_chk (
  input wire logic       clk, reset, pin_override_enable, ovr_power_enable,
  input wire logic       ovr_mode_one, ovr_mode_two, ovr_emulation, attach_detect,
  input wire logic       fault_event, ration_reached, ration_clear, port_switch_closed,
  input wire logic       data_switch_closed, polarity_latched, fault_notify_n,
  input wire logic       attach_flag_n, charge_quota_done,
  input wire logic [2:0] op_state_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // State expected for each mode word
  localparam logic [2:0] DEC [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h1, 3'h2, 3'h5};
  logic [2:0] cnt;       // Edges since reset, saturating
  logic [2:0] next_cnt;
  logic [2:0] word;      // Override mode word
  assign word = {ovr_mode_one, ovr_mode_two, ovr_emulation};
  // Saturate so polarity capture is long past
  always_comb next_cnt = (cnt == 3'h5) ? cnt : cnt + 3'h1;
  always_ff @(posedge clk) cnt <= reset ? 3'h0 : next_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Ration limit hit, then sticky done
  sequence s_ration;
    ration_reached ##1 charge_quota_done;
  endsequence
  a_decode_state:
    assert property (pin_override_enable |=> op_state_out == DEC[$past(word)]) else $error("decode");
  a_polarity_hold:
    assert property (cnt >= 3'h4 |-> $stable(polarity_latched)) else $error("polarity moved");
  a_switch_close:
    assert property (cnt >= 3'h4 && pin_override_enable && word != 3'h0 && !ration_reached
      && ovr_power_enable == polarity_latched && !charge_quota_done |=> port_switch_closed)
      else $error("switch open");
  a_switch_mismatch:
    assert property (cnt >= 3'h4 && pin_override_enable && ovr_power_enable != polarity_latched
      |=> !port_switch_closed) else $error("switch closed");
  a_fault_low:
    assert property (fault_event |=> !fault_notify_n) else $error("fault high");
  a_attach_follow:
    assert property (!$past(reset) |-> attach_flag_n == !$past(attach_detect))
      else $error("attach flag");
  a_quota_keep:
    assert property (charge_quota_done && !ration_clear |=> charge_quota_done) else $error("lost");
  a_pass_data:
    assert property (data_switch_closed == (port_switch_closed && op_state_out == 3'h2))
      else $error("data switch");
  a_ration_stop:
    assert property (s_ration |-> !fault_notify_n && !port_switch_closed) else $error("ration");
  a_safe_open:
    assert property (op_state_out == 3'h0 |-> !port_switch_closed) else $error("safe");
endmodule // port_power_mode_chk

/* portable_device_model.sv */
/* Portable device at the port: raises attach sense after plug-in.
   Assumes the bench moves plug just after the clock edge. */
module portable_device_model (
  input  wire logic clk,                 // Port clock
  input  wire logic plug,                // Cable present
  output logic      attach_detect = 1'h0 // Attach sense
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sense lags the cable a cycle, like a detector
  always_ff @(posedge clk) attach_detect <= plug;
endmodule // portable_device_model

/* port_power_mode_pin_logic_test.sv */
/* Self-checking bench for the port power mode pin logic.
   Assumes the package and the checker are compiled first. */
module port_power_mode_pin_logic_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] EXP [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h1, 3'h2, 3'h5};
  logic       clk = 0, reset = 1, pol = 1, lat = 1, ovr_en = 0, plug = 0;
  logic [3:0] pins = 4'h0, ovr = 4'h0; // {enable, one, two, emulation}
  logic       f_ev = 0, r_ev = 0, r_clr = 0, f_clr = 0, att, sw, dsw, pl, f_n, a_n, done, emu;
  logic [2:0] st;
  int         n_fail = 0, checked = 0, seed = 33745;
  port_power_mode_pin_logic i_dut (.clk(clk), .reset(reset), .polarity_choice_pin(pol),
    .port_power_enable(pins[3]), .mode_select_one(pins[2]), .mode_select_two(pins[1]),
    .emulation_enable(pins[0]), .pin_override_enable(ovr_en), .ovr_power_enable(ovr[3]),
    .ovr_mode_one(ovr[2]), .ovr_mode_two(ovr[1]), .ovr_emulation(ovr[0]),
    .attach_detect(att), .fault_event(f_ev), .ration_reached(r_ev), .ration_clear(r_clr),
    .fault_clear(f_clr), .port_switch_closed(sw), .data_switch_closed(dsw),
    .emulation_active(emu), .op_state_out(st), .polarity_latched(pl),
    .fault_notify_n(f_n), .attach_flag_n(a_n), .charge_quota_done(done));
  portable_device_model i_dev (.clk(clk), .plug(plug), .attach_detect(att));
  // Edges to wait, then settle past the updates
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmp(input string what, input logic [2:0] e, input logic [2:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic stop_test;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic power_up(input logic p);
    pol = p;
    lat = p;
    reset = 1;
    tick(5);
    reset = 0;
    tick(6);
  endtask
  // Override word; random pin levels must be ignored
  task automatic try_ovr(input logic [3:0] v);
    logic e_sw;
    ovr = v;
    pins = 4'($random(seed));
    e_sw = v[3] == lat && v[2:0] != 3'h0;
    tick(2);
    cmp("op_state_out", EXP[v[2:0]], st);
    cmp("port_switch_closed", 3'(e_sw), 3'(sw));
    cmp("data_switch_closed", 3'(e_sw && EXP[v[2:0]] == 3'h2), 3'(dsw));
    cmp("emulation_active", 3'(e_sw && EXP[v[2:0]] != 3'h2), 3'(emu));
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    tick(1);
    s = 0;
    tick(1);
  endtask
  initial forever #2.5 clk = ~clk;
  // Watchdog well past the expected run
  initial begin
    #20000;
    n_fail++;
    stop_test;
  end
  initial begin
    power_up(1'b1);
    cmp("polarity_latched", 3'h1, 3'(pl));
    ovr_en = 1;
    for (int i = 0; i < 16; i++) try_ovr(4'(i));
    repeat (20) try_ovr(4'($random(seed)));
    pol = 0;
    tick(5);
    try_ovr(4'hA);
    cmp("polarity_latched", 3'h1, 3'(pl));
    $display("test override ended");
    ovr_en = 0;
    ovr = 4'h0;
    pins = 4'hF;
    tick(5);
    cmp("op_state_out", 3'h5, st);
    pulse(f_ev);
    cmp("fault_notify_n", 3'h0, 3'(f_n));
    pulse(f_clr);
    cmp("fault_notify_n", 3'h1, 3'(f_n));
    pulse(r_ev);
    cmp("ration", 3'h4, {done, f_n, sw});
    tick(50);
    cmp("charge_quota_done", 3'h1, 3'(done));
    pulse(r_clr);
    cmp("ration", 3'h3, {done, f_n, sw});
    plug = 1;
    tick(3);
    cmp("attach_flag_n", 3'h0, 3'(a_n));
    plug = 0;
    tick(3);
    cmp("attach_flag_n", 3'h1, 3'(a_n));
    $display("test alerts ended");
    power_up(1'b0);
    cmp("polarity_latched", 3'h0, 3'(pl));
    ovr_en = 1;
    try_ovr(4'h3);
    try_ovr(4'hB);
    $display("test repower ended");
    stop_test;
  end
endmodule // port_power_mode_pin_logic_test
bind port_power_mode_pin_logic port_power_mode_chk i_chk (.clk, .reset, .pin_override_enable,
  .ovr_power_enable, .ovr_mode_one, .ovr_mode_two, .ovr_emulation, .attach_detect,
  .fault_event, .ration_reached, .ration_clear, .port_switch_closed, .data_switch_closed,
  .polarity_latched, .fault_notify_n, .attach_flag_n, .charge_quota_done, .op_state_out);
